/* File: hdl/irap_pkg.sv */
// constants and types shared by the indexed register access port
package irap_pkg;
    // host i/o addresses, 10-bit decode of the address pins
    localparam logic [9:0] ADDR_INDEX = 10'h3e0;
    localparam logic [9:0] ADDR_WINDOW = 10'h3e1;
    // field positions inside the index selector
    localparam int IDX_SOCKET_BIT = 6;
    localparam int IDX_DEVICE_BIT = 7;
    // register numbers inside one socket's 64-entry space
    localparam logic [5:0] REG_CHIP_REV = 6'h00;
    localparam logic [5:0] REG_MISC2 = 6'h1e;
    localparam logic [5:0] REG_CHIP_INFO = 6'h1f;
    localparam logic [5:0] REG_EXT_SEL = 6'h2e;
    localparam logic [5:0] REG_EXT_WIN = 6'h2f;
    // extended index space
    localparam logic [7:0] EXT_SCRATCH = 8'h00;
    localparam logic [7:0] EXT_MASK0 = 8'h01;
    localparam logic [7:0] EXT_MASK1 = 8'h02;
    localparam logic [7:0] EXT_CTRL1 = 8'h03;
    localparam logic [7:0] EXT_DMA_DELAY = 8'h04;
    localparam logic [7:0] EXT_RSV_FIRST = 8'h05;
    localparam logic [7:0] EXT_RSV_LAST = 8'h09;
    localparam logic [7:0] EXT_EXT_DATA = 8'h0a;
    localparam logic [7:0] EXT_CTRL2 = 8'h0b;
    // misc control two: suspend mode bit
    localparam int MISC2_SUSPEND_BIT = 2;
    // reset values
    localparam logic [7:0] INDEX_RESET = 8'h00;
    localparam logic [7:0] EXT_SEL_RESET = 8'h00;
    localparam logic [7:0] MISC2_RESET = 8'h02;
    // cycles the strap waits after reset so its synchroniser has filled
    localparam logic [1:0] STRAP_SETTLE = 2'h2;
    // register store geometry
    localparam int MEM_AW = 8;
    localparam int MEM_DW = 8;
    // what a data window access lands on
    typedef enum logic [2:0] {KIND_NONE, KIND_MEM, KIND_REV, KIND_INFO, KIND_MISC2,
        KIND_EXT_SEL} irap_kind_e;
    // host cycle phases
    typedef enum logic [1:0] {PH_IDLE, PH_FETCH, PH_DRIVE} irap_phase_e;
    // host pins as sampled
    typedef struct packed {
        logic [9:0] addr;
        logic [15:0] din;
        logic rd_b;
        logic wr_b;
        logic sbhe_b;
        logic ok;
        logic strap;
    } irap_pin_s;
    // decoded target of a window access
    typedef struct packed {
        irap_kind_e kind;
        logic [7:0] maddr;
        logic mine;
    } irap_win_s;
    localparam irap_pin_s PIN_IDLE = '{addr: 10'h000, din: 16'h0000, rd_b: 1'b1,
        wr_b: 1'b1, sbhe_b: 1'b1, ok: 1'b0, strap: 1'b0};
endpackage

/* File: hdl/irap_mem_if.sv */
// port between the access logic and its register store
`timescale 1ns/1ps
interface irap_mem_if #(parameter int AW = 8, parameter int DW = 8);
    logic we; // one-cycle write strobe
    logic [AW-1:0] addr; // byte address, read and write
    logic [DW-1:0] wdata; // write byte
    logic [DW-1:0] rdata; // registered read byte, one cycle after addr
    modport ctrl (output we, output addr, output wdata, input rdata);
    modport store (input we, input addr, input wdata, output rdata);
endinterface

/* File: hdl/irap_reg_store.sv */
// byte store for socket and extension registers, registered read
`timescale 1ns/1ps
module irap_reg_store #(
    parameter int AW = 8,
    parameter int DW = 8
) (
    input wire logic core_clk,
    irap_mem_if.store mp
);
    // storage; deliberately has no reset so it costs no reset tree
    logic [DW-1:0] mem_q [2**AW];

    // write then read of the same address returns the old byte
    always_ff @(posedge core_clk) begin
        if (mp.we) begin
            mem_q[mp.addr] <= mp.wdata;
        end
        mp.rdata <= mem_q[mp.addr];
    end
endmodule

/* File: hdl/irap_top.sv */
// indexed host register access port: index selector, data window, extension window
// What this block does
// - two i/o addresses reach every register byte
// - index at 3e0h, data window at 3e1h
// - index bits 5:0 pick one of 64
// - index bit 6 picks socket a or b
// - index bit 7 picks one of two devices
// - window access uses the index held then, or the index a word write at 3e0h loads
// - index reads back on device 0 only
// - socket b copy sits at index plus 40h
// - revision, misc two, info shared by sockets
// - extended selector 2eh and window 2fh
// - extended map 00h to 0bh, 05h-09h reserved
// - only bits with reset values get reset
// - strap latched at reset picks served socket
// - compatibility bits have no effect
// - fixed bits forced at reset, ignore writes
// - scratchpad bits are plain storage
// - host write never sets a status bit
// - reset values return when supply cycles
// - suspend allows only index and 8-bit misc two access
`timescale 1ns/1ps
module irap_top
    import irap_pkg::*;
#(
    parameter bit DEVICE_NUM = 1'b0, // which of two devices this one is
    parameter bit DUAL_SOCKET = 1'b1, // 0 builds the single-socket variant
    parameter logic [7:0] REV_VALUE = 8'h5a, // arbitrary value
    parameter logic [7:0] INFO_VALUE = 8'ha5 // arbitrary value
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic supply_ok_input,
    input wire logic socket_select_strap,
    input wire logic [9:0] io_addr,
    input wire logic io_rd_b,
    input wire logic io_wr_b,
    input wire logic io_sbhe_b,
    input wire logic [15:0] data_in,
    output logic [15:0] data_out,
    output logic data_oe_lo_b,
    output logic data_oe_hi_b,
    output logic suspend_active,
    output logic served_socket
);
    // whole state of the port
    typedef struct packed {
        irap_pin_s pin1; // first synchroniser stage, read only by pin2
        irap_pin_s pin2; // second stage, used by logic
        logic rd_prev_b; // pin2 strobes one cycle late for edges
        logic wr_prev_b;
        logic [1:0] settle; // strap settle count
        logic strap_done;
        logic strap; // latched socket choice
        logic [7:0] index; // index selector
        logic [7:0] ext_sel_a; // extended selector, socket a
        logic [7:0] ext_sel_b; // extended selector, socket b
        logic [7:0] misc2; // shared misc control two
        irap_phase_e phase;
        logic use_mem; // read byte comes from the store
        logic [7:0] hold; // read byte for non-store targets
        logic lo_win; // window byte goes on the low lane
        logic drive_lo;
        logic drive_hi;
        logic [15:0] dout;
        logic oe_lo_b;
        logic oe_hi_b;
    } irap_state_s;

    irap_state_s q; // registered state
    irap_state_s d; // next state
    irap_mem_if #(.AW(MEM_AW), .DW(MEM_DW)) mif (); // store port

    // decode helpers, all from registered state
    logic rd_go; // read strobe just asserted
    logic wr_go; // write strobe just asserted
    logic hit; // address is one of our two
    logic a0; // odd address
    logic wide; // 16-bit word access
    logic touch_win; // access carries a window byte
    logic [7:0] new_idx; // index in force for this access
    logic [7:0] win_byte; // window byte on the data pins
    logic ok_win; // window access is allowed
    irap_win_s win; // decoded window target

    // map an index value onto its target
    function automatic irap_win_s win_map(input logic [7:0] idx, input logic [7:0] ext_a,
        input logic [7:0] ext_b, input logic strap);
        irap_win_s w;
        logic sock;
        logic [7:0] ext;
        w.kind = KIND_MEM;
        w.mine = (idx[IDX_DEVICE_BIT] == DEVICE_NUM);
        sock = idx[IDX_SOCKET_BIT];
        ext = sock ? ext_b : ext_a;
        w.maddr = {1'b0, sock, idx[5:0]};
        unique case (idx[5:0])
            REG_CHIP_REV: w.kind = KIND_REV;
            REG_MISC2: w.kind = KIND_MISC2;
            REG_CHIP_INFO: w.kind = KIND_INFO;
            REG_EXT_SEL: w.kind = KIND_EXT_SEL;
            REG_EXT_WIN: begin
                // reserved and unmapped extended entries read zero
                if (ext > EXT_CTRL2 || (ext >= EXT_RSV_FIRST && ext <= EXT_RSV_LAST)) begin
                    w.kind = KIND_NONE;
                end else begin
                    w.maddr = {1'b1, sock, 2'b00, ext[3:0]};
                end
            end
            default: w.kind = KIND_MEM;
        endcase
        // unbuilt socket of the single variant: reads zero, writes dropped
        if (!DUAL_SOCKET && sock != strap) begin
            w.kind = KIND_NONE;
        end
        return w;
    endfunction

    // strobe edges and address decode
    assign rd_go = !q.pin2.rd_b && q.rd_prev_b;
    assign wr_go = !q.pin2.wr_b && q.wr_prev_b;
    assign hit = (q.pin2.addr[9:1] == ADDR_INDEX[9:1]);
    assign a0 = q.pin2.addr[0];
    assign wide = !q.pin2.sbhe_b && !a0;
    assign touch_win = a0 || wide;
    // a word write at the index address uses the index it is loading
    assign new_idx = (wr_go && !a0) ? q.pin2.din[7:0] : q.index;
    assign win_byte = q.pin2.sbhe_b ? q.pin2.din[7:0] : q.pin2.din[15:8];
    assign win = win_map(new_idx, q.ext_sel_a, q.ext_sel_b, q.strap);
    // in suspend only a byte access to misc control two passes
    assign ok_win = win.mine && (!q.misc2[MISC2_SUSPEND_BIT]
        || (win.kind == KIND_MISC2 && !wide));

    // next-state logic
    always_comb begin
        d = q;
        mif.we = 1'b0;
        mif.addr = win.maddr;
        mif.wdata = win_byte;
        d.pin1 = '{addr: io_addr, din: data_in, rd_b: io_rd_b, wr_b: io_wr_b,
            sbhe_b: io_sbhe_b, ok: supply_ok_input, strap: socket_select_strap};
        d.pin2 = q.pin1;
        d.rd_prev_b = q.pin2.rd_b;
        d.wr_prev_b = q.pin2.wr_b;
        // catch the strap once, after the synchroniser holds its real level
        if (!q.strap_done) begin
            if (q.settle == STRAP_SETTLE) begin
                d.strap = q.pin2.strap;
                d.strap_done = 1'b1;
            end else begin
                d.settle = q.settle + 2'h1;
            end
        end
        unique case (q.phase)
            PH_IDLE: begin
                if (wr_go && hit) begin
                    // both devices track the shared index selector
                    if (!a0) begin
                        d.index = q.pin2.din[7:0];
                    end
                    if (touch_win && ok_win) begin
                        unique case (win.kind)
                            // socket registers are stored as written; their
                            // compatibility and scratchpad bits steer nothing
                            KIND_MEM: mif.we = 1'b1;
                            KIND_MISC2: d.misc2 = win_byte;
                            KIND_EXT_SEL: begin
                                if (new_idx[IDX_SOCKET_BIT]) begin
                                    d.ext_sel_b = win_byte;
                                end else begin
                                    d.ext_sel_a = win_byte;
                                end
                            end
                            // fixed and reported bytes drop host writes
                            default: d.misc2 = q.misc2;
                        endcase
                    end
                end else if (rd_go && hit) begin
                    d.lo_win = a0 && q.pin2.sbhe_b;
                    // device 1 never returns the index byte
                    d.drive_lo = (!a0 && DEVICE_NUM == 1'b0)
                        || (a0 && q.pin2.sbhe_b && ok_win);
                    d.drive_hi = !q.pin2.sbhe_b && touch_win && ok_win;
                    d.use_mem = (win.kind == KIND_MEM);
                    unique case (win.kind)
                        // revision and info report fixed conditions
                        KIND_REV: d.hold = REV_VALUE;
                        KIND_INFO: d.hold = INFO_VALUE;
                        KIND_MISC2: d.hold = q.misc2;
                        KIND_EXT_SEL: d.hold = q.index[IDX_SOCKET_BIT] ? q.ext_sel_b
                            : q.ext_sel_a;
                        default: d.hold = 8'h00;
                    endcase
                    if (d.drive_lo || d.drive_hi) begin
                        d.phase = PH_FETCH;
                    end
                end
            end
            PH_FETCH: begin
                // store byte is valid now; lanes turn on together with data
                d.dout = q.lo_win ? {8'h00, (q.use_mem ? mif.rdata : q.hold)}
                    : {(q.use_mem ? mif.rdata : q.hold), q.index};
                d.oe_lo_b = !q.drive_lo;
                d.oe_hi_b = !q.drive_hi;
                d.phase = PH_DRIVE;
            end
            PH_DRIVE: begin
                // hold the bus until the host lifts its read strobe
                if (q.pin2.rd_b) begin
                    d.oe_lo_b = 1'b1;
                    d.oe_hi_b = 1'b1;
                    d.phase = PH_IDLE;
                end
            end
        endcase
        // supply low: the host keeps strobes high; registers go back
        // to their reset values and the bus is released
        if (!q.pin2.ok) begin
            mif.we = 1'b0;
            d.index = INDEX_RESET;
            d.ext_sel_a = EXT_SEL_RESET;
            d.ext_sel_b = EXT_SEL_RESET;
            d.misc2 = MISC2_RESET;
            d.phase = PH_IDLE;
            d.oe_lo_b = 1'b1;
            d.oe_hi_b = 1'b1;
        end
    end

    // state register
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '0;
            q.pin1 <= PIN_IDLE;
            q.pin2 <= PIN_IDLE;
            q.rd_prev_b <= 1'b1;
            q.wr_prev_b <= 1'b1;
            q.index <= INDEX_RESET;
            q.ext_sel_a <= EXT_SEL_RESET;
            q.ext_sel_b <= EXT_SEL_RESET;
            q.misc2 <= MISC2_RESET;
            q.oe_lo_b <= 1'b1;
            q.oe_hi_b <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // socket register store
    irap_reg_store #(.AW(MEM_AW), .DW(MEM_DW)) u_store (
        .core_clk(core_clk),
        .mp(mif)
    );

    // outputs straight from flops
    assign data_out = q.dout;
    assign data_oe_lo_b = q.oe_lo_b;
    assign data_oe_hi_b = q.oe_hi_b;
    assign suspend_active = q.misc2[MISC2_SUSPEND_BIT];
    assign served_socket = q.strap;

    // checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_lanes_off_then_on;
        (q.oe_lo_b && q.oe_hi_b) ##1 (!q.oe_lo_b || !q.oe_hi_b);
    endsequence

    sequence s_fetch_then_drive;
        (q.phase == PH_FETCH) ##1 (q.phase == PH_DRIVE);
    endsequence

    chk_index_load: assert property (
        (q.phase == PH_IDLE && wr_go && hit && !a0 && q.pin2.ok)
        |=> q.index == $past(q.pin2.din[7:0]))
        else $error("index selector not loaded by write at index address");

    chk_supply_reset: assert property (
        !q.pin2.ok |=> (q.index == INDEX_RESET && q.misc2 == MISC2_RESET
            && q.oe_lo_b && q.oe_hi_b))
        else $error("supply low did not restore reset values");

    chk_read_answer: assert property (
        (q.phase == PH_IDLE && d.phase == PH_FETCH) |=> s_fetch_then_drive
        and s_lanes_off_then_on)
        else $error("read did not drive data two cycles after the strobe edge");

    chk_read_release: assert property (
        (q.phase == PH_DRIVE && q.pin2.rd_b) |=> (q.oe_lo_b && q.oe_hi_b
        && q.phase == PH_IDLE))
        else $error("bus not released after read strobe lifted");

    chk_dev1_index: assert property (
        (!q.oe_lo_b && !q.lo_win) |-> (DEVICE_NUM == 1'b0))
        else $error("device 1 drove the index byte");

    chk_fixed_bytes: assert property (
        mif.we |-> !(mif.addr[7] == 1'b0 && (mif.addr[5:0] == REG_CHIP_REV
        || mif.addr[5:0] == REG_CHIP_INFO || mif.addr[5:0] == REG_MISC2)))
        else $error("store written at a shared fixed register");

    chk_suspend_gate: assert property (
        q.misc2[MISC2_SUSPEND_BIT] |-> !mif.we)
        else $error("store written while suspended");

    chk_ext_range: assert property (
        (mif.we && mif.addr[7]) |-> (mif.addr[3:0] <= EXT_CTRL2[3:0]
        && !(mif.addr[3:0] >= EXT_RSV_FIRST[3:0] && mif.addr[3:0] <= EXT_RSV_LAST[3:0])))
        else $error("write landed in reserved extended space");

    chk_strap_hold: assert property (
        q.strap_done |=> (q.strap_done && q.strap == $past(q.strap)))
        else $error("latched strap changed after capture");

    chk_word_write: assert property (
        (q.phase == PH_IDLE && wr_go && hit && wide && q.pin2.ok
        && win.kind == KIND_MEM && ok_win)
        |-> (mif.we && mif.wdata == q.pin2.din[15:8] && mif.addr[6] == q.pin2.din[6]
            && (q.pin2.din[5:0] == REG_EXT_WIN ? mif.addr[7]
            : mif.addr[5:0] == q.pin2.din[5:0])))
        else $error("word write at index did not write the new register");

    chk_single_socket: assert property (
        (mif.we && !DUAL_SOCKET) |-> (mif.addr[6] == q.strap))
        else $error("single-socket variant wrote the missing socket");

    // a refused window read leaves both lanes off and the port idle
    chk_refused_read: assert property (
        (q.phase == PH_IDLE && rd_go && hit && a0 && !ok_win)
        |=> (q.phase == PH_IDLE && q.oe_lo_b && q.oe_hi_b))
        else $error("refused window read drove the bus");

    // a byte read of misc control two is answered, suspended or not
    chk_misc2_answer: assert property (
        (q.phase == PH_IDLE && rd_go && q.pin2.wr_b && hit && a0 && q.pin2.sbhe_b
        && win.mine && win.kind == KIND_MISC2 && q.pin2.ok) |=> q.phase == PH_FETCH)
        else $error("byte read of misc control two was refused");
endmodule

/* File: verif/irap_host_model.sv */
// host cpu model issuing isa i/o read and write cycles
`timescale 1ns/1ps
module irap_host_model (
    input wire logic core_clk,
    input wire logic supply_ok_input,
    input wire logic [15:0] data_out,
    input wire logic data_oe_lo_b,
    input wire logic data_oe_hi_b,
    output logic [9:0] io_addr,
    output logic io_rd_b,
    output logic io_wr_b,
    output logic io_sbhe_b,
    output logic [15:0] data_in
);
    logic [15:0] last_d; // last byte pair the host drove
    // idle pins: strobes high, released bus shows the inverse of the last write
    initial begin
        io_addr = 10'h000;
        io_rd_b = 1'b1;
        io_wr_b = 1'b1;
        io_sbhe_b = 1'b1;
        last_d = 16'h0000;
        data_in = 16'hffff;
    end
    // one write; strobe held four cycles so the two-stage synchroniser sees it
    task automatic wr(input logic [9:0] a, input logic sb, input logic [15:0] d);
        @(negedge core_clk);
        if (supply_ok_input === 1'b1) begin
            io_addr = a;
            io_sbhe_b = sb;
            data_in = d;
            last_d = d;
            @(negedge core_clk);
            io_wr_b = 1'b0;
            repeat (4) @(negedge core_clk);
            io_wr_b = 1'b1;
            // hold address and data while the raised strobe crosses the sync
            repeat (4) @(negedge core_clk);
            data_in = ~last_d;
        end
    endtask
    // one read; hit tells whether any lane was driven within the bound
    task automatic rd(input logic [9:0] a, input logic sb, output logic [15:0] q,
        output logic hit);
        int n;
        q = 16'h0000;
        hit = 1'b0;
        @(negedge core_clk);
        io_addr = a;
        io_sbhe_b = sb;
        @(negedge core_clk);
        io_rd_b = 1'b0;
        for (n = 0; n < 10 && hit == 1'b0; n++) begin
            // look half a cycle after launch, when the lanes have settled
            @(negedge core_clk);
            if (data_oe_lo_b === 1'b0 || data_oe_hi_b === 1'b0) begin
                hit = 1'b1;
                q = data_out;
            end
        end
        @(negedge core_clk);
        io_rd_b = 1'b1;
        // enough high time for the strobe edge to be seen again
        repeat (5) @(negedge core_clk);
    endtask
endmodule

/* File: verif/tb_indexed_register_access_port.sv */
// self-checking bench for the indexed register access port
`timescale 1ns/1ps
module tb_indexed_register_access_port;
    import irap_pkg::*;
    localparam logic [7:0] REV = 8'h5a; // arbitrary value
    localparam logic [7:0] INFO = 8'ha5; // arbitrary value
    logic core_clk, rst_b, supply_ok_input, socket_select_strap;
    logic [9:0] io_addr;
    logic io_rd_b, io_wr_b, io_sbhe_b, data_oe_lo_b, data_oe_hi_b;
    logic suspend_active, served_socket;
    logic [15:0] data_in, data_out, q;
    logic [15:0] dout0, dout1; // read lanes of each device
    logic oe0_lo_b, oe0_hi_b, oe1_lo_b, oe1_hi_b; // lane enables of each device
    logic hit;
    logic [7:0] v, r;
    logic [7:0] shadow [0:127]; // expected store contents, both sockets
    int miscompares, compares, seed, i;
    irap_top #(.DEVICE_NUM(1'b0), .DUAL_SOCKET(1'b1), .REV_VALUE(REV),
        .INFO_VALUE(INFO)) DUT (.core_clk(core_clk), .rst_b(rst_b),
        .supply_ok_input(supply_ok_input), .socket_select_strap(socket_select_strap),
        .io_addr(io_addr), .io_rd_b(io_rd_b), .io_wr_b(io_wr_b), .io_sbhe_b(io_sbhe_b),
        .data_in(data_in), .data_out(dout0), .data_oe_lo_b(oe0_lo_b),
        .data_oe_hi_b(oe0_hi_b), .suspend_active(suspend_active),
        .served_socket(served_socket));
    // second device on the same addresses, single-socket build
    irap_top #(.DEVICE_NUM(1'b1), .DUAL_SOCKET(1'b0), .REV_VALUE(REV),
        .INFO_VALUE(INFO)) DUT1 (.core_clk(core_clk), .rst_b(rst_b),
        .supply_ok_input(supply_ok_input), .socket_select_strap(socket_select_strap),
        .io_addr(io_addr), .io_rd_b(io_rd_b), .io_wr_b(io_wr_b), .io_sbhe_b(io_sbhe_b),
        .data_in(data_in), .data_out(dout1), .data_oe_lo_b(oe1_lo_b),
        .data_oe_hi_b(oe1_hi_b), .suspend_active(), .served_socket());
    // shared data bus: each lane shows whichever device enables it
    assign data_oe_lo_b = oe0_lo_b && oe1_lo_b;
    assign data_oe_hi_b = oe0_hi_b && oe1_hi_b;
    assign data_out = {(oe1_hi_b ? dout0[15:8] : dout1[15:8]),
        (oe1_lo_b ? dout0[7:0] : dout1[7:0])};
    irap_host_model host (.core_clk(core_clk), .supply_ok_input(supply_ok_input),
        .data_out(data_out), .data_oe_lo_b(data_oe_lo_b), .data_oe_hi_b(data_oe_hi_b),
        .io_addr(io_addr), .io_rd_b(io_rd_b), .io_wr_b(io_wr_b), .io_sbhe_b(io_sbhe_b),
        .data_in(data_in));
    // 50 mhz clock
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // expected window byte: the fixed revision and info registers ignore the socket bit
    function automatic logic [7:0] exp_rd(input logic [7:0] idx);
        if (idx[5:0] == REG_CHIP_REV) return REV;
        if (idx[5:0] == REG_CHIP_INFO) return INFO;
        return shadow[idx[6:0]];
    endfunction
    // one comparison, counted
    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask
    // word write at the index address: index on the low lane, data on the high
    task automatic wrw(input logic [7:0] idx, input logic [7:0] d);
        host.wr(ADDR_INDEX, 1'b0, {d, idx});
        if (idx[5:0] != REG_CHIP_REV && idx[5:0] != REG_CHIP_INFO) shadow[idx[6:0]] = d;
    endtask
    // byte index write then byte window read
    task automatic rdb(input logic [7:0] idx, output logic [7:0] d, output logic h);
        logic [15:0] w;
        host.wr(ADDR_INDEX, 1'b1, {8'h00, idx});
        host.rd(ADDR_WINDOW, 1'b1, w, h);
        d = w[7:0];
    endtask
    // verdict, printed once
    task automatic complete_run();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // watchdog far beyond the expected run length
    initial begin
        #(20 * 40000);
        miscompares++;
        complete_run();
    end
    // main sequence
    initial begin
        seed = 40;
        miscompares = 0;
        compares = 0;
        rst_b = 1'b0;
        supply_ok_input = 1'b1;
        socket_select_strap = 1'b1;
        repeat (12) @(negedge core_clk);
        rst_b = 1'b1;
        repeat (6) @(negedge core_clk);
        chk("served_socket", 16'h1, {15'h0, served_socket});
        chk("suspend", 16'h0, {15'h0, suspend_active});
        chk("oe_lo", 16'h1, {15'h0, data_oe_lo_b});
        host.rd(ADDR_INDEX, 1'b1, q, hit);
        chk("index reset", {8'h01, INDEX_RESET}, {7'h0, hit, q[7:0]});
        $display("test reset done");
        // random index values read back on device 0
        for (i = 0; i < 4; i++) begin
            v = 8'($random(seed));
            host.wr(ADDR_INDEX, 1'b1, {8'h00, v});
            host.rd(ADDR_INDEX, 1'b1, q, hit);
            chk("index", {8'h01, v}, {7'h0, hit, q[7:0]});
        end
        $display("test index done");
        // socket a and b copies hold different bytes; boundary 3fh included
        for (i = 0; i < 10; i++) begin
            r = (i == 0) ? 8'h3f : 8'h01 + 8'($unsigned($random(seed)) % 29);
            // 01h is always written, later checks read it back
            if (i == 1) r = 8'h01;
            v = 8'($random(seed));
            wrw(r, v);
            wrw(r | 8'h40, ~v);
            rdb(r, v, hit);
            chk("socket a", {8'h01, exp_rd(r)}, {7'h0, hit, v});
            rdb(r | 8'h40, v, hit);
            chk("socket b", {8'h01, exp_rd(r | 8'h40)}, {7'h0, hit, v});
        end
        $display("test sockets done");
        // revision ignores a write; revision and info ignore the socket bit
        wrw({2'b00, REG_CHIP_REV}, 8'h33);
        rdb(8'h40, v, hit);
        chk("rev", {8'h01, REV}, {7'h0, hit, v});
        rdb({2'b01, REG_CHIP_INFO}, v, hit);
        chk("info", {8'h01, INFO}, {7'h0, hit, v});
        // byte window write, then a high-lane window read
        v = 8'($random(seed));
        host.wr(ADDR_INDEX, 1'b1, 16'h0027);
        host.wr(ADDR_WINDOW, 1'b1, {8'h00, v});
        shadow[7'h27] = v;
        host.rd(ADDR_WINDOW, 1'b0, q, hit);
        chk("window hi", {8'h01, v}, {7'h0, hit, q[15:8]});
        $display("test window done");
        // extension registers through the second level of indexing
        for (i = 0; i < 3; i++) begin
            wrw({2'b00, REG_EXT_SEL}, 8'(i));
            wrw({2'b00, REG_EXT_WIN}, 8'h90 + 8'(i));
        end
        wrw({2'b01, REG_EXT_SEL}, EXT_CTRL2);
        for (i = 0; i < 3; i++) begin
            wrw({2'b00, REG_EXT_SEL}, 8'(i));
            rdb({2'b00, REG_EXT_WIN}, v, hit);
            chk("ext", {8'h01, 8'h90 + 8'(i)}, {7'h0, hit, v});
        end
        rdb(8'h6e, v, hit);
        chk("ext sel b", {8'h01, EXT_CTRL2}, {7'h0, hit, v});
        wrw({2'b00, REG_EXT_SEL}, EXT_RSV_FIRST);
        wrw({2'b00, REG_EXT_WIN}, 8'hff);
        rdb({2'b00, REG_EXT_WIN}, v, hit);
        chk("ext reserved", 16'h0100, {7'h0, hit, v});
        $display("test extended done");
        // bit 7 set: device 1 answers; its socket a is not built, so it reads zero
        host.wr(ADDR_INDEX, 1'b1, 16'h0081);
        host.wr(ADDR_WINDOW, 1'b1, 16'h00c3);
        host.rd(ADDR_WINDOW, 1'b1, q, hit);
        chk("other device", 16'h0100, {7'h0, hit, q[7:0]});
        host.wr(ADDR_INDEX, 1'b1, 16'h00c1);
        host.wr(ADDR_WINDOW, 1'b1, 16'h00c3);
        host.rd(ADDR_INDEX, 1'b0, q, hit);
        chk("device 1 word", 16'hc3c1, q);
        chk("device 1 hit", 16'h1, {15'h0, hit});
        rdb(8'h01, v, hit);
        chk("no stray write", {8'h01, exp_rd(8'h01)}, {7'h0, hit, v});
        $display("test device done");
        // suspend: only byte access to misc control two; the read checks only the suspend bit
        host.wr(ADDR_INDEX, 1'b1, {10'h0, REG_MISC2});
        host.wr(ADDR_WINDOW, 1'b1, 16'h0006);
        chk("suspend on", 16'h1, {15'h0, suspend_active});
        rdb(8'h01, v, hit);
        chk("suspend refuse", 16'h0, {15'h0, hit});
        rdb({2'b00, REG_MISC2}, v, hit);
        chk("misc2 read", 16'h3, {14'h0, hit, v[MISC2_SUSPEND_BIT]});
        $display("test suspend done");
        // supply cycle returns reset values, store keeps its bytes
        host.wr(ADDR_INDEX, 1'b1, 16'h0055);
        @(negedge core_clk);
        supply_ok_input = 1'b0;
        repeat (5) @(negedge core_clk);
        supply_ok_input = 1'b1;
        repeat (5) @(negedge core_clk);
        chk("suspend off", 16'h0, {15'h0, suspend_active});
        host.rd(ADDR_INDEX, 1'b1, q, hit);
        chk("index cycled", {8'h01, INDEX_RESET}, {7'h0, hit, q[7:0]});
        rdb(8'h27, v, hit);
        chk("scratch kept", {8'h01, exp_rd(8'h27)}, {7'h0, hit, v});
        $display("test supply done");
        complete_run();
    end
endmodule
